// [design/led_driver_diagnostic_regs.sv]
// Read-only diagnostic register group of a six-channel LED driver.
// Assumes live values come from core-clock logic; the serial port front end
// delivers decoded register requests on the same clock.
// Functional notes
// - Bit 7 internal short, cleared with aggregate
// - Bit 6 open fault, cleared with aggregate
// - Bits 5-0 channel 1..6 fault flags
// - Bits 4-0 show live state code
// - Measured PWM input duty, 16 bits
// - Configured PWM output duty, bits 15-0
// - Sink DAC code bits 11-0, upper zero
// - Boost code bits 10-0, 15-11 zero
// - Strap bit 15 zero; all reset zero
// - Mode field gives mode and bus address
// - Bits 14-12 give detected PWM frequency
`include "led_diag_regs.svh"
`default_nettype none
module led_driver_diagnostic_regs (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire led_diag_pkg::reg_req_s req_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    input wire led_diag_pkg::fault_evt_s fault_evt_i,
    input wire logic [4:0] live_state_code_i,
    input wire logic [15:0] pwm_in_duty_i,
    input wire logic [15:0] pwm_out_duty_i,
    input wire logic [11:0] sink_dac_code_i,
    input wire logic [10:0] converter_voltage_code_i,
    input wire logic strap_valid_i,
    input wire led_diag_pkg::strap_s strap_i,
    output logic aggregate_fault_status_o,
    output logic [6:0] detected_bus_addr_o
);
    logic [4:0] state_q;
    logic [15:0] pwm_in_q;
    logic [15:0] pwm_out_q;
    logic [11:0] sink_q;
    logic [10:0] boost_q;
    led_diag_pkg::strap_s strap_q;
    logic aggregate_fault_status_reg;
    logic internal_short_flag_reg;
    logic open_string_flag_reg;
    logic [5:0] channel_fault_reg;
    logic fault_clear;
    logic any_fault;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;

    // Live views follow their sources every cycle; writes never reach them
    diag_capture #(.W(5)) u_state (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_i(1'b1),
        .d_i(live_state_code_i), .q_o(state_q));
    diag_capture #(.W(16)) u_pwm_in (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_i(1'b1),
        .d_i(pwm_in_duty_i), .q_o(pwm_in_q));
    diag_capture #(.W(16)) u_pwm_out (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_i(1'b1),
        .d_i(pwm_out_duty_i), .q_o(pwm_out_q));
    diag_capture #(.W(12)) u_sink (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_i(1'b1),
        .d_i(sink_dac_code_i), .q_o(sink_q));
    diag_capture #(.W(11)) u_boost (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_i(1'b1),
        .d_i(converter_voltage_code_i), .q_o(boost_q));
    // Strap result holds zero until detection reports done
    diag_capture #(.W(12)) u_strap (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_i(strap_valid_i),
        .d_i(strap_i), .q_o(strap_q));

    // Clear needs both status and clear bits written as one, as for other faults
    assign fault_clear = req_i.wr_en && (req_i.addr == `LED_FAULT_FLAGS_OFS)
        && req_i.wdata[`AGG_STATUS_BIT] && req_i.wdata[`AGG_CLEAR_BIT];
    assign any_fault = fault_evt_i.internal_short_flag || fault_evt_i.open_string_flag
        || (|fault_evt_i.channel_fault);

    // A fault arriving in the clear cycle wins over the clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            aggregate_fault_status_reg <= 1'b0;
        end else if (any_fault) begin
            aggregate_fault_status_reg <= 1'b1;
        end else if (fault_clear) begin
            aggregate_fault_status_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            internal_short_flag_reg <= 1'b0;
        end else if (fault_evt_i.internal_short_flag) begin
            internal_short_flag_reg <= 1'b1;
        end else if (fault_clear) begin
            internal_short_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            open_string_flag_reg <= 1'b0;
        end else if (fault_evt_i.open_string_flag) begin
            open_string_flag_reg <= 1'b1;
        end else if (fault_clear) begin
            open_string_flag_reg <= 1'b0;
        end
    end

    // Per-channel flags stay sticky so a brief fault is not missed by a slow host
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            channel_fault_reg <= 6'h00;
        end else begin
            channel_fault_reg <= (fault_clear ? 6'h00 : channel_fault_reg)
                | fault_evt_i.channel_fault;
        end
    end

    // Read mux; write data is only ever inspected for the fault clear
    always_comb begin
        rdata_next = `DIAG_RESET_VALUE;
        unique case (req_i.addr)
            `LED_FAULT_FLAGS_OFS: begin
                rdata_next[`AGG_STATUS_BIT] = aggregate_fault_status_reg;
                rdata_next[`SHORT_FLAG_BIT] = internal_short_flag_reg;
                rdata_next[`OPEN_FLAG_BIT] = open_string_flag_reg;
                rdata_next[`CHAN_FLAGS_MSB:`CHAN_FLAGS_LSB] = channel_fault_reg;
            end
            `STATE_MACHINE_VIEW_OFS: rdata_next[`STATE_CODE_MSB:0] = state_q;
            `PWM_IN_DUTY_VIEW_OFS: rdata_next = pwm_in_q;
            `PWM_OUT_DUTY_VIEW_OFS: rdata_next = pwm_out_q;
            `SINK_CURRENT_CODE_VIEW_OFS: rdata_next[`SINK_CODE_MSB:0] = sink_q;
            `BOOST_VOLTAGE_CODE_VIEW_OFS: rdata_next[`BOOST_CODE_MSB:0] = boost_q;
            `STRAP_DETECT_VIEW_OFS: begin
                rdata_next[`DIM_FREQ_MSB:`DIM_FREQ_LSB] =
                    strap_q.detected_dim_frequency;
                rdata_next[`LAYOUT_MSB:`LAYOUT_LSB] = strap_q.detected_string_layout;
                rdata_next[`SW_FREQ_MSB:`SW_FREQ_LSB] =
                    strap_q.detected_switching_frequency;
                rdata_next[`MODE_MSB:`MODE_LSB] = strap_q.dimming_mode;
            end
            default: rdata_next = `DIAG_RESET_VALUE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= `DIAG_RESET_VALUE;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= req_i.rd_en;
            if (req_i.rd_en) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign aggregate_fault_status_o = aggregate_fault_status_reg;
    assign detected_bus_addr_o = strap_q.dimming_mode[`MODE_ADDR_SEL_BIT]
        ? `BUS_ADDR_HIGH_MODES : `BUS_ADDR_LOW_MODES;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_clear_only;
        fault_clear && !fault_evt_i.internal_short_flag && !fault_evt_i.open_string_flag;
    endsequence
    sequence s_read(logic [7:0] ofs);
        req_i.rd_en && (req_i.addr == ofs);
    endsequence

    a_short_set_sticky: assert property (fault_evt_i.internal_short_flag ##1 !fault_clear
        |=> internal_short_flag_reg && aggregate_fault_status_reg)
        else $error("short flag not held");
    a_short_clear_done: assert property (s_clear_only |=> !internal_short_flag_reg)
        else $error("short flag not cleared");
    a_open_clear_done: assert property (s_clear_only |=> !open_string_flag_reg)
        else $error("open flag not cleared");
    a_open_set_wins: assert property (fault_evt_i.open_string_flag && fault_clear
        |=> open_string_flag_reg)
        else $error("open flag lost to clear");
    a_chan_flag_read: assert property (fault_evt_i.channel_fault[0] ##1
        s_read(`LED_FAULT_FLAGS_OFS) ##0 !fault_clear |=> rdata_o[0])
        else $error("channel 1 flag missing");
    a_state_code_read: assert property (s_read(`STATE_MACHINE_VIEW_OFS)
        |=> rdata_o == {11'h000, $past(state_q)} && rvalid_o)
        else $error("state code read wrong");
    a_pwm_in_path: assert property (s_read(`PWM_IN_DUTY_VIEW_OFS)
        |=> rdata_o == $past(pwm_in_duty_i, 2))
        else $error("pwm input duty read wrong");
    a_pwm_out_path: assert property (s_read(`PWM_OUT_DUTY_VIEW_OFS)
        |=> rdata_o == $past(pwm_out_duty_i, 2))
        else $error("pwm output duty read wrong");
    a_sink_upper_zero: assert property (s_read(`SINK_CURRENT_CODE_VIEW_OFS)
        |=> rdata_o[15:12] == 4'h0 && rdata_o[11:0] == $past(sink_q))
        else $error("sink code read wrong");
    a_boost_upper_zero: assert property (s_read(`BOOST_VOLTAGE_CODE_VIEW_OFS)
        |=> rdata_o[15:11] == 5'h00 && rdata_o[10:0] == $past(boost_q))
        else $error("boost code read wrong");
    a_strap_reserved_zero: assert property (s_read(`STRAP_DETECT_VIEW_OFS)
        |=> rdata_o[15] == 1'b0 && rdata_o[11] == 1'b0)
        else $error("strap reserved bit set");
    a_reset_reads_zero: assert property ($past(sys_rst_i) |-> rdata_o == 16'h0000
        && !aggregate_fault_status_reg && strap_q == 12'h000)
        else $error("state not zero after reset");
    a_dim_freq_field: assert property (s_read(`STRAP_DETECT_VIEW_OFS)
        |=> rdata_o[14:12] == $past(strap_q.detected_dim_frequency))
        else $error("dim frequency field wrong");
    a_bus_addr_map: assert property (strap_q.dimming_mode[2]
        |-> detected_bus_addr_o == 7'h2A)
        else $error("bus address decode wrong");
    a_bus_addr_low: assert property (!strap_q.dimming_mode[2]
        |-> detected_bus_addr_o == 7'h2B)
        else $error("low mode bus address wrong");
    a_write_ignored: assert property (req_i.wr_en && !strap_valid_i
        |=> strap_q == $past(strap_q))
        else $error("write disturbed strap view");
    // A write that is not a full clear, with no fault event, must leave the channel flags and aggregate status alone
    a_write_keeps_flags: assert property (req_i.wr_en && !fault_clear && !any_fault
        |=> channel_fault_reg == $past(channel_fault_reg)
        && aggregate_fault_status_reg == $past(aggregate_fault_status_reg))
        else $error("write disturbed fault flags");
endmodule
`default_nettype wire

// [design/led_diag_regs.svh]
// Register offsets, field positions and reset values of the diagnostic group.
// Assumes byte offsets as seen on the device's serial register port.
`ifndef LED_DIAG_REGS_SVH
`define LED_DIAG_REGS_SVH

`define LED_FAULT_FLAGS_OFS 8'h12
`define STATE_MACHINE_VIEW_OFS 8'h14
`define PWM_IN_DUTY_VIEW_OFS 8'h16
`define PWM_OUT_DUTY_VIEW_OFS 8'h18
`define SINK_CURRENT_CODE_VIEW_OFS 8'h1A
`define BOOST_VOLTAGE_CODE_VIEW_OFS 8'h1C
`define STRAP_DETECT_VIEW_OFS 8'h1E

`define DIAG_RESET_VALUE 16'h0000

`define AGG_STATUS_BIT 10
`define AGG_CLEAR_BIT 9
`define SHORT_FLAG_BIT 7
`define OPEN_FLAG_BIT 6
`define CHAN_FLAGS_MSB 5
`define CHAN_FLAGS_LSB 0

`define STATE_CODE_MSB 4
`define SINK_CODE_MSB 11
`define BOOST_CODE_MSB 10

`define DIM_FREQ_MSB 14
`define DIM_FREQ_LSB 12
`define LAYOUT_MSB 10
`define LAYOUT_LSB 8
`define SW_FREQ_MSB 5
`define SW_FREQ_LSB 3
`define MODE_MSB 2
`define MODE_LSB 0
`define MODE_ADDR_SEL_BIT 2

`define BUS_ADDR_LOW_MODES 7'h2B
`define BUS_ADDR_HIGH_MODES 7'h2A

`endif

// [design/led_diag_pkg.sv]
// Types shared by the diagnostic register group.
// Assumes all producers of live values run on the core clock.
`default_nettype none
package led_diag_pkg;

    typedef struct packed {
        logic internal_short_flag;
        logic open_string_flag;
        logic [5:0] channel_fault;
    } fault_evt_s;

    typedef struct packed {
        logic [2:0] detected_dim_frequency;
        logic [2:0] detected_string_layout;
        logic [2:0] detected_switching_frequency;
        logic [2:0] dimming_mode;
    } strap_s;

    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

endpackage
`default_nettype wire

// [design/diag_capture.sv]
// Loadable capture register that reads zero from reset until first load.
// Assumes d_i comes from logic on the same clock.
`default_nettype none
module diag_capture #(
    parameter int W = 16
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] q_reg;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            q_reg <= '0;
        end else if (load_i) begin
            q_reg <= d_i;
        end
    end

    assign q_o = q_reg;
endmodule
`default_nettype wire

// [bench/diag_host_model.sv]
// Host side of the register port: turns bench commands into one-cycle requests.
// Assumes the device answers a read with one rvalid pulse on the core clock.
`default_nettype none
module diag_host_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output var led_diag_pkg::reg_req_s req_o,
    output logic done_o,
    output logic [15:0] rd_value_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            req_o <= '0;
        end else if (cmd_valid_i) begin
            req_o.rd_en <= !cmd_write_i;
            req_o.wr_en <= cmd_write_i;
            req_o.addr <= cmd_addr_i;
            req_o.wdata <= cmd_wdata_i;
        end else begin
            // Idle bus shows junk, so a stale address can never pass for a request
            req_o.rd_en <= 1'b0;
            req_o.wr_en <= 1'b0;
            req_o.addr <= ~req_o.addr;
            req_o.wdata <= ~req_o.wdata;
        end
    end
    always_ff @(posedge core_clk_i) begin
        done_o <= rvalid_i;
        rd_value_o <= rdata_i;
    end
endmodule
`default_nettype wire

// [bench/led_driver_diagnostic_regs_tb_top.sv]
// Self-checking bench for the diagnostic register group.
// Assumes the host model sits on the register port; all other inputs are bench driven.
`default_nettype none
module led_driver_diagnostic_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    led_diag_pkg::reg_req_s req;
    logic [15:0] rdata;
    logic rvalid;
    logic done;
    logic [15:0] rd_value;
    led_diag_pkg::fault_evt_s evt = '0;
    logic [4:0] state = 5'h00;
    logic [15:0] pin = 16'h0000;
    logic [15:0] pout = 16'h0000;
    logic [11:0] sink = 12'h000;
    logic [10:0] boost = 11'h000;
    logic strap_valid = 1'b0;
    led_diag_pkg::strap_s strap = '0;
    logic [11:0] sv = 12'h000;
    logic agg;
    logic [6:0] bus_addr;
    logic [31:0] seed = 32'hCA187FB3;
    logic [31:0] r;
    logic [15:0] v;
    int bad_count = 0;
    int n_compared = 0;

    diag_host_model host (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
        .cmd_wdata_i(cmd_wdata), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req),
        .done_o(done), .rd_value_o(rd_value));
    led_driver_diagnostic_regs dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .fault_evt_i(evt),
        .live_state_code_i(state), .pwm_in_duty_i(pin), .pwm_out_duty_i(pout),
        .sink_dac_code_i(sink), .converter_voltage_code_i(boost),
        .strap_valid_i(strap_valid), .strap_i(strap), .aggregate_fault_status_o(agg),
        .detected_bus_addr_o(bus_addr));

    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] expv(input logic [7:0] a);
        case (a)
            8'h14: return {11'h000, state};
            8'h16: return pin;
            8'h18: return pout;
            8'h1A: return {4'h0, sink};
            8'h1C: return {5'h00, boost};
            8'h1E: return {1'b0, sv[11:9], 1'b0, sv[8:6], 2'b00, sv[5:3], sv[2:0]};
            default: return 16'h0000;
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge core_clk_i);
        cmd_valid <= 1'b0;
        // Reads finish on the model's done flag; writes have no answer to wait for
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk_i);
            #1;
            if (!wr && done === 1'b1) break;
            if (!wr && k == 7) check(16'hDEAD, 16'hBEEF);
        end
        v = rd_value;
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 8'h12; a <= 8'h20; a += 2) begin
            access(1'b0, 8'(a), 16'h0000);
            check(v, 16'h0000);
        end
        for (int i = 0; i < 20; i++) begin
            r = xs();
            @(posedge core_clk_i);
            state <= 5'(i);
            pin <= r[15:0];
            pout <= r[31:16];
            sink <= r[27:16];
            boost <= r[10:0];
            strap <= r[11:0];
            strap_valid <= 1'b1;
            sv = r[11:0];
            @(posedge core_clk_i);
            strap_valid <= 1'b0;
            strap <= r[23:12];
            // The decode follows the strap view, which settles just after this edge
            #1;
            check({9'h000, bus_addr}, {9'h000, sv[2] ? 7'h2A : 7'h2B});
            for (int j = 0; j < 6; j++) begin
                access(1'b1, 8'(8'h14 + 2 * j), xs());
                access(1'b0, 8'(8'h14 + 2 * j), 16'h0000);
                check(v, expv(8'(8'h14 + 2 * j)));
            end
        end
        for (int k = 0; k < 8; k++) begin
            // Event stands through a partial write, a read and a clear: set must win
            @(posedge core_clk_i);
            evt <= 8'(1 << k);
            access(1'b1, 8'h12, 16'h0400);
            access(1'b0, 8'h12, 16'h0000);
            check(v, {5'h00, 1'b1, 2'b00, 8'(1 << k)});
            check({15'h0000, agg}, 16'h0001);
            access(1'b1, 8'h12, 16'h0600);
            access(1'b0, 8'h12, 16'h0000);
            check(v, {5'h00, 1'b1, 2'b00, 8'(1 << k)});
            @(posedge core_clk_i);
            evt <= '0;
            access(1'b1, 8'h12, 16'h0600);
            access(1'b0, 8'h12, 16'h0000);
            check(v, 16'h0000);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
